// ==== logic/bbie_params.svh ====
`ifndef BBIE_PARAMS_SVH
`define BBIE_PARAMS_SVH

// Operand and field widths of the instruction group.
`define BBIE_DATA_W 8
`define BBIE_INDEX_W 7
`define BBIE_POS_W 3

// Destination select encodings.
`define BBIE_TARGET_ACC 1'b0
`define BBIE_TARGET_FILE 1'b1

// Reset values of the datapath state.
`define BBIE_ACC_RST 8'h00
`define BBIE_ZERO_BYTE 8'h00
`define BBIE_INDEX_RST 7'h00
`define BBIE_FLAG_RST 1'b0

// Position of the low-nibble carry and the byte carry in the adder results.
`define BBIE_NIBBLE_CARRY_BIT 4
`define BBIE_BYTE_CARRY_BIT 8

// A taken skip replaces exactly one following slot.
`define BBIE_SKIP_SLOTS 1

`endif

// ==== logic/bbie_pkg.sv ====
`include "bbie_params.svh"

package bbie_pkg;

  // One-hot operation codes presented by the sequencer.
  typedef enum logic [7:0] {
    BBIE_OP_ADD_LIT = 8'h01,
    BBIE_OP_ADD_REG = 8'h02,
    BBIE_OP_AND_REG = 8'h04,
    BBIE_OP_AND_LIT = 8'h08,
    BBIE_OP_CLR_BIT = 8'h10,
    BBIE_OP_SET_BIT = 8'h20,
    BBIE_OP_TST_BIT = 8'h40,
    BBIE_OP_CLR_REG = 8'h80
  } bbie_op_t;

  // Execution state: normal slot or substituted idle slot.
  typedef enum logic [1:0] {
    BBIE_ST_RUN = 2'b01,
    BBIE_ST_IDLE = 2'b10
  } bbie_state_t;

  // One decoded instruction.
  typedef struct packed {
    bbie_op_t op;
    logic [`BBIE_DATA_W-1:0] literal_value;
    logic [`BBIE_INDEX_W-1:0] register_index;
    logic result_target;
    logic [`BBIE_POS_W-1:0] position_select;
  } bbie_instr_t;

  // Write-back request towards the file register array.
  typedef struct packed {
    logic we;
    logic [`BBIE_INDEX_W-1:0] addr;
    logic [`BBIE_DATA_W-1:0] data;
  } bbie_wb_t;

  // Status bits kept by the datapath.
  typedef struct packed {
    logic carry;
    logic nibble_overflow_flag;
    logic result_null_flag;
  } bbie_flags_t;

endpackage : bbie_pkg

// ==== logic/bbie_exec.sv ====
// What this block does
// - Literal plus accumulator into accumulator, flags.
// - Accumulator plus file register to target, flags.
// - Target zero means accumulator, one file register.
// - Accumulator AND register to target, null only.
// - Accumulator AND literal into accumulator, null only.
// - Clear chosen bit, others and flags kept.
// - Set chosen bit, others and flags kept.
// - Bit zero discards next instruction as idle.
// - Taken skip spans own cycle plus idle.
// - Clear register to zero, set null flag.
`timescale 1ns/1ps
`include "bbie_params.svh"

module bbie_exec (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Instruction from the sequencer.
  input wire logic INSTR_VALID,
  input wire bbie_pkg::bbie_instr_t INSTR,
  // Current contents of the addressed file register.
  input wire logic [`BBIE_DATA_W-1:0] FILE_RDATA,
  // Write-back towards the file register array.
  output bbie_pkg::bbie_wb_t WB,
  // Accumulator and status bits.
  output logic [`BBIE_DATA_W-1:0] ACC,
  output bbie_pkg::bbie_flags_t FLAGS,
  // Skip handling.
  output logic SKIP_PENDING,
  output logic IDLE_SLOT
);
  import bbie_pkg::*;

  logic [`BBIE_DATA_W-1:0] acc_reg;
  logic [`BBIE_DATA_W-1:0] acc_next;
  bbie_flags_t flags_reg;
  bbie_flags_t flags_next;
  bbie_wb_t wb_reg;
  bbie_wb_t wb_next;
  bbie_state_t state_reg;
  bbie_state_t state_next;
  logic idle_reg;
  logic take;
  logic [`BBIE_DATA_W-1:0] operand;
  logic [`BBIE_DATA_W:0] sum;
  logic [`BBIE_NIBBLE_CARRY_BIT:0] nib_sum;
  logic [`BBIE_DATA_W-1:0] and_res;
  logic [`BBIE_DATA_W-1:0] bit_mask;
  logic tested_bit;

  // An instruction is only taken in a normal slot; in the idle slot it is dropped.
  assign take = INSTR_VALID && (state_reg == BBIE_ST_RUN);

  // Shared adder: the literal feeds it for the literal form, the file register otherwise.
  assign operand = (INSTR.op == BBIE_OP_ADD_LIT) ? INSTR.literal_value : FILE_RDATA;
  assign sum = {1'b0, acc_reg} + {1'b0, operand};
  assign nib_sum = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
  assign and_res = acc_reg & operand;
  assign bit_mask = 8'h01 << INSTR.position_select;
  assign tested_bit = FILE_RDATA[INSTR.position_select];

  // Next-state of accumulator, flags and write-back for the taken instruction.
  always_comb begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    wb_next.we = 1'b0;
    wb_next.addr = INSTR.register_index;
    wb_next.data = `BBIE_ZERO_BYTE;
    if (take) begin
      case (INSTR.op)
        BBIE_OP_ADD_LIT: begin
          acc_next = sum[`BBIE_DATA_W-1:0];
          flags_next.carry = sum[`BBIE_BYTE_CARRY_BIT];
          flags_next.nibble_overflow_flag = nib_sum[`BBIE_NIBBLE_CARRY_BIT];
          flags_next.result_null_flag = (sum[`BBIE_DATA_W-1:0] == `BBIE_ZERO_BYTE);
        end
        BBIE_OP_ADD_REG: begin
          flags_next.carry = sum[`BBIE_BYTE_CARRY_BIT];
          flags_next.nibble_overflow_flag = nib_sum[`BBIE_NIBBLE_CARRY_BIT];
          flags_next.result_null_flag = (sum[`BBIE_DATA_W-1:0] == `BBIE_ZERO_BYTE);
          if (INSTR.result_target == `BBIE_TARGET_FILE) begin
            wb_next.we = 1'b1;
            wb_next.data = sum[`BBIE_DATA_W-1:0];
          end else begin
            acc_next = sum[`BBIE_DATA_W-1:0];
          end
        end
        BBIE_OP_AND_REG: begin
          flags_next.result_null_flag = (and_res == `BBIE_ZERO_BYTE);
          if (INSTR.result_target == `BBIE_TARGET_FILE) begin
            wb_next.we = 1'b1;
            wb_next.data = and_res;
          end else begin
            acc_next = and_res;
          end
        end
        BBIE_OP_AND_LIT: begin
          acc_next = acc_reg & INSTR.literal_value;
          flags_next.result_null_flag = ((acc_reg & INSTR.literal_value) == `BBIE_ZERO_BYTE);
        end
        BBIE_OP_CLR_BIT: begin
          wb_next.we = 1'b1;
          wb_next.data = FILE_RDATA & ~bit_mask;
        end
        BBIE_OP_SET_BIT: begin
          wb_next.we = 1'b1;
          wb_next.data = FILE_RDATA | bit_mask;
        end
        BBIE_OP_CLR_REG: begin
          wb_next.we = 1'b1;
          wb_next.data = `BBIE_ZERO_BYTE;
          flags_next.result_null_flag = 1'b1;
        end
        default: begin
          acc_next = acc_reg;
        end
      endcase
    end
  end

  // Slot sequencing: a zero tested bit turns the following slot into an idle one.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BBIE_ST_RUN: begin
        if (take && (INSTR.op == BBIE_OP_TST_BIT) && !tested_bit) begin
          state_next = BBIE_ST_IDLE;
        end
      end
      BBIE_ST_IDLE: begin
        state_next = BBIE_ST_RUN;
      end
      default: begin
        state_next = BBIE_ST_RUN;
      end
    endcase
  end

  // Accumulator register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      acc_reg <= `BBIE_ACC_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Status bits; bit operations and the skip leave them as they were.
  always_ff @(posedge CLK) begin
    if (RST) begin
      flags_reg <= {`BBIE_FLAG_RST, `BBIE_FLAG_RST, `BBIE_FLAG_RST};
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Write-back request, a one-cycle strobe with its address and data.
  always_ff @(posedge CLK) begin
    if (RST) begin
      wb_reg <= {1'b0, `BBIE_INDEX_RST, `BBIE_ZERO_BYTE};
    end else begin
      wb_reg <= wb_next;
    end
  end

  // Slot state and the idle marker; the idle marker follows the discarded slot.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= BBIE_ST_RUN;
      idle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idle_reg <= (state_reg == BBIE_ST_IDLE);
    end
  end

  // Outputs straight from flip-flops.
  assign ACC = acc_reg;
  assign FLAGS = flags_reg;
  assign WB = wb_reg;
  // One-hot state, so the idle bit is the flag itself and no decode sits between flop and pin.
  assign SKIP_PENDING = state_reg[1];
  assign IDLE_SLOT = idle_reg;

  // Reference values computed apart from the datapath for the checks below.
  logic [`BBIE_DATA_W:0] chk_lit_sum;
  logic [`BBIE_DATA_W:0] chk_reg_sum;
  logic chk_lit_dc;
  logic chk_reg_dc;
  logic [`BBIE_DATA_W-1:0] chk_and_lit;
  logic [`BBIE_DATA_W-1:0] chk_and_reg;
  logic [`BBIE_DATA_W-1:0] chk_clr;
  logic [`BBIE_DATA_W-1:0] chk_set;
  assign chk_lit_sum = {1'b0, ACC} + {1'b0, INSTR.literal_value};
  assign chk_reg_sum = {1'b0, ACC} + {1'b0, FILE_RDATA};
  assign chk_lit_dc = ({1'b0, ACC[3:0]} + {1'b0, INSTR.literal_value[3:0]} > 5'h0f);
  assign chk_reg_dc = ({1'b0, ACC[3:0]} + {1'b0, FILE_RDATA[3:0]} > 5'h0f);
  assign chk_and_lit = ACC & INSTR.literal_value;
  assign chk_and_reg = ACC & FILE_RDATA;
  assign chk_clr = FILE_RDATA & ~(8'h01 << INSTR.position_select);
  assign chk_set = FILE_RDATA | (8'h01 << INSTR.position_select);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_op(bbie_op_t o);
    INSTR_VALID && !SKIP_PENDING && INSTR.op == o;
  endsequence

  sequence s_skip_taken;
    s_op(BBIE_OP_TST_BIT) ##0 !FILE_RDATA[INSTR.position_select];
  endsequence

  sequence s_idle_then_clean;
    SKIP_PENDING ##1 (IDLE_SLOT && !WB.we && $stable(ACC) && $stable(FLAGS) && !SKIP_PENDING);
  endsequence

  add_lit_sum_a: assert property (s_op(BBIE_OP_ADD_LIT) |=>
    {FLAGS.carry, ACC} == $past(chk_lit_sum) && FLAGS.nibble_overflow_flag == $past(chk_lit_dc))
    else $error("literal add result or flags wrong");

  add_reg_carry_a: assert property (s_op(BBIE_OP_ADD_REG) |=>
    FLAGS.carry == $past(chk_reg_sum[8]) && FLAGS.nibble_overflow_flag == $past(chk_reg_dc))
    else $error("register add carry flags wrong");

  add_reg_file_a: assert property (s_op(BBIE_OP_ADD_REG) ##0 INSTR.result_target |=>
    WB.we && WB.addr == $past(INSTR.register_index) && {FLAGS.carry, WB.data} == $past(chk_reg_sum)
    && $stable(ACC))
    else $error("register add write-back wrong");

  acc_target_a: assert property ((s_op(BBIE_OP_ADD_REG) or s_op(BBIE_OP_AND_REG))
    ##0 !INSTR.result_target |=> !WB.we)
    else $error("accumulator target still wrote the file");

  and_reg_flags_a: assert property (s_op(BBIE_OP_AND_REG) ##0 !INSTR.result_target |=>
    ACC == $past(chk_and_reg) && $stable(FLAGS.carry) && $stable(FLAGS.nibble_overflow_flag))
    else $error("register and result or flags wrong");

  and_lit_a: assert property (s_op(BBIE_OP_AND_LIT) |=>
    ACC == $past(chk_and_lit) && !WB.we && $stable(FLAGS.carry))
    else $error("literal and result wrong");

  bit_clear_a: assert property (s_op(BBIE_OP_CLR_BIT) |=>
    WB.we && WB.data == $past(chk_clr) && $stable(FLAGS) && $stable(ACC))
    else $error("bit clear wrong");

  bit_set_a: assert property (s_op(BBIE_OP_SET_BIT) |=>
    WB.we && WB.data == $past(chk_set) && $stable(FLAGS) && $stable(ACC))
    else $error("bit set wrong");

  skip_taken_a: assert property (s_skip_taken |=> s_idle_then_clean)
    else $error("skip did not give exactly one idle slot");

  skip_not_a: assert property (s_op(BBIE_OP_TST_BIT) ##0 FILE_RDATA[INSTR.position_select]
    |=> !SKIP_PENDING && !WB.we && $stable(FLAGS) ##1 !IDLE_SLOT)
    else $error("set bit caused a skip");

  clear_reg_a: assert property (s_op(BBIE_OP_CLR_REG) |=>
    WB.we && WB.data == 8'h00 && FLAGS.result_null_flag && $stable(ACC))
    else $error("register clear wrong");

  null_flag_a: assert property ((s_op(BBIE_OP_ADD_LIT) or s_op(BBIE_OP_AND_LIT) or
    s_op(BBIE_OP_ADD_REG) or s_op(BBIE_OP_AND_REG)) |=>
    FLAGS.result_null_flag == ((WB.we ? WB.data : ACC) == 8'h00))
    else $error("null flag does not match result");

  // The accumulator form of the register add must land in the accumulator and leave the file alone.
  add_reg_acc_a: assert property (s_op(BBIE_OP_ADD_REG) ##0 !INSTR.result_target |=>
    ACC == $past(chk_reg_sum[7:0]) && !WB.we)
    else $error("register add into accumulator wrong");

  // The file form of the register AND writes back and keeps the accumulator and both carries.
  and_reg_file_a: assert property (s_op(BBIE_OP_AND_REG) ##0 INSTR.result_target |=>
    WB.we && WB.addr == $past(INSTR.register_index) && WB.data == $past(chk_and_reg)
    && $stable(ACC) && $stable(FLAGS.carry) && $stable(FLAGS.nibble_overflow_flag))
    else $error("register and write-back wrong");

  // Bit operations and the register clear must hit the register that was addressed.
  bit_addr_a: assert property ((s_op(BBIE_OP_CLR_BIT) or s_op(BBIE_OP_SET_BIT)
    or s_op(BBIE_OP_CLR_REG)) |=>
    WB.we && WB.addr == $past(INSTR.register_index))
    else $error("bit operation wrote the wrong register");

  // The bit test itself writes nothing and moves no status bit, whichever way it goes.
  tst_quiet_a: assert property (s_op(BBIE_OP_TST_BIT) |=>
    !WB.we && $stable(ACC) && $stable(FLAGS))
    else $error("bit test changed state");

  // Whatever the sequencer shows in the discarded slot must leave no trace.
  skip_discard_a: assert property (SKIP_PENDING |=>
    !WB.we && $stable(ACC) && $stable(FLAGS) && !SKIP_PENDING)
    else $error("discarded slot had an effect");

  // The idle marker is a single-cycle pulse; a stuck marker would hide later skips.
  idle_pulse_a: assert property (IDLE_SLOT |=> !IDLE_SLOT)
    else $error("idle marker held too long");

  // Reset must bring every output to its idle value by the next edge.
  reset_state_a: assert property (disable iff (1'b0) RST |=>
    ACC == 8'h00 && FLAGS == 3'b000 && !WB.we && !SKIP_PENDING && !IDLE_SLOT)
    else $error("outputs not cleared by reset");

endmodule : bbie_exec

// ==== verif/bbie_file_model.sv ====
`timescale 1ns/1ps
`include "bbie_params.svh"

module bbie_file_model (
  // Clock.
  input wire logic clk,
  // Read address and write-back from the block.
  input wire logic [`BBIE_INDEX_W-1:0] raddr,
  input wire bbie_pkg::bbie_wb_t wb,
  // Read data of the addressed file register.
  output logic [`BBIE_DATA_W-1:0] rdata
);
  import bbie_pkg::*;

  logic [`BBIE_DATA_W-1:0] mem [0:127];

  // A write still in flight is forwarded, because the next instruction reads in the same cycle.
  assign rdata = (wb.we && (wb.addr == raddr)) ? wb.data : mem[raddr];

  // Plain always so that the bench may preload the array at time zero.
  always @(posedge clk) begin
    if (wb.we) begin
      mem[wb.addr] <= wb.data;
    end
  end
endmodule : bbie_file_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`include "bbie_params.svh"

module tb_top;
  import bbie_pkg::*;

  logic CLK, RST, INSTR_VALID, SKIP_PENDING, IDLE_SLOT;
  bbie_instr_t INSTR;
  logic [7:0] FILE_RDATA, ACC, acc_m;
  bbie_wb_t WB;
  bbie_flags_t FLAGS, flg_m;
  logic [7:0] fr [0:127];
  int n_fail = 0;
  int total_checks = 0;

  bbie_exec dut_u (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
    .WB(WB), .ACC(ACC), .FLAGS(FLAGS), .SKIP_PENDING(SKIP_PENDING), .IDLE_SLOT(IDLE_SLOT));
  bbie_file_model file_u (.clk(CLK), .raddr(INSTR.register_index), .wb(WB), .rdata(FILE_RDATA));

  // Instruction clock, 4 ns period.
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Issues one instruction, predicts its effect from our own model and compares one cycle later.
  task automatic op_run(input bbie_op_t op, input logic [7:0] k, input logic [6:0] ix, input logic t,
    input logic [2:0] p);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] f, r, ea;
    logic w;
    bbie_flags_t ef;
    ea = acc_m;
    ef = flg_m;
    w = 1'b0;
    f = (op inside {BBIE_OP_ADD_LIT, BBIE_OP_AND_LIT}) ? k : fr[ix];
    s = {1'b0, acc_m} + {1'b0, f};
    n = {1'b0, acc_m[3:0]} + {1'b0, f[3:0]};
    r = (op inside {BBIE_OP_AND_LIT, BBIE_OP_AND_REG}) ? (acc_m & f) : s[7:0];
    case (op)
      BBIE_OP_ADD_LIT, BBIE_OP_ADD_REG, BBIE_OP_AND_LIT, BBIE_OP_AND_REG: begin
        if (op inside {BBIE_OP_ADD_LIT, BBIE_OP_ADD_REG}) begin
          ef.carry = s[8];
          ef.nibble_overflow_flag = n[4];
        end
        ef.result_null_flag = (r == 8'h00);
        w = (op inside {BBIE_OP_ADD_REG, BBIE_OP_AND_REG}) && t;
        if (!w) ea = r;
      end
      BBIE_OP_CLR_BIT: begin
        r = fr[ix] & ~(8'h01 << p);
        w = 1'b1;
      end
      BBIE_OP_SET_BIT: begin
        r = fr[ix] | (8'h01 << p);
        w = 1'b1;
      end
      BBIE_OP_CLR_REG: begin
        r = 8'h00;
        w = 1'b1;
        ef.result_null_flag = 1'b1;
      end
      default: ;
    endcase
    @(posedge CLK);
    INSTR <= '{op, k, ix, t, p};
    INSTR_VALID <= 1'b1;
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    #1;
    chk(ACC, ea);
    chk({5'h00, FLAGS}, {5'h00, ef});
    chk({7'h00, WB.we}, {7'h00, w});
    chk({7'h00, SKIP_PENDING}, {7'h00, (op == BBIE_OP_TST_BIT) && !fr[ix][p]});
    if (w) begin
      chk({1'b0, WB.addr}, {1'b0, ix});
      chk(WB.data, r);
      fr[ix] = r;
    end
    acc_m = ea;
    flg_m = ef;
  endtask : op_run

  task automatic t_arith;
    op_run(BBIE_OP_ADD_LIT, 8'h0f, 7'h00, 1'b0, 3'h0);
    op_run(BBIE_OP_ADD_LIT, 8'h01, 7'h00, 1'b0, 3'h0);
    op_run(BBIE_OP_ADD_LIT, 8'hf0, 7'h00, 1'b0, 3'h0);
    op_run(BBIE_OP_ADD_LIT, 8'hff, 7'h00, 1'b0, 3'h0);
    op_run(BBIE_OP_ADD_REG, 8'h00, 7'h7f, 1'b1, 3'h0);
    op_run(BBIE_OP_ADD_REG, 8'h00, 7'h05, 1'b0, 3'h0);
    op_run(BBIE_OP_ADD_REG, 8'h00, 7'h7f, 1'b0, 3'h0);
    op_run(BBIE_OP_AND_LIT, 8'hff, 7'h00, 1'b0, 3'h0);
    op_run(BBIE_OP_AND_REG, 8'h00, 7'h03, 1'b1, 3'h0);
    op_run(BBIE_OP_AND_REG, 8'h00, 7'h03, 1'b0, 3'h0);
    op_run(BBIE_OP_AND_LIT, 8'h00, 7'h00, 1'b0, 3'h0);
    $display("test arith done");
  endtask : t_arith

  task automatic t_bits;
    op_run(BBIE_OP_ADD_LIT, 8'h8f, 7'h00, 1'b0, 3'h0);
    for (int i = 0; i < 8; i++) begin
      op_run(BBIE_OP_SET_BIT, 8'h00, 7'h14, 1'b0, 3'(i));
      op_run(BBIE_OP_CLR_BIT, 8'h00, 7'h15, 1'b0, 3'(i));
    end
    op_run(BBIE_OP_CLR_REG, 8'h00, 7'h7f, 1'b0, 3'h0);
    $display("test bits done");
  endtask : t_bits

  // A taken skip must swallow the instruction presented in the following slot.
  task automatic t_skip;
    op_run(BBIE_OP_SET_BIT, 8'h00, 7'h09, 1'b0, 3'h2);
    op_run(BBIE_OP_TST_BIT, 8'h00, 7'h09, 1'b0, 3'h2);
    op_run(BBIE_OP_CLR_BIT, 8'h00, 7'h09, 1'b0, 3'h5);
    @(posedge CLK);
    INSTR <= '{BBIE_OP_TST_BIT, 8'h00, 7'h09, 1'b0, 3'h5};
    INSTR_VALID <= 1'b1;
    @(posedge CLK);
    INSTR <= '{BBIE_OP_ADD_LIT, 8'h11, 7'h00, 1'b0, 3'h0};
    #1;
    chk({7'h00, SKIP_PENDING}, 8'h01);
    chk({5'h00, FLAGS}, {5'h00, flg_m});
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    #1;
    chk({7'h00, IDLE_SLOT}, 8'h01);
    chk({7'h00, SKIP_PENDING}, 8'h00);
    chk(ACC, acc_m);
    chk({7'h00, WB.we}, 8'h00);
    @(posedge CLK);
    #1;
    chk({7'h00, IDLE_SLOT}, 8'h00);
    $display("test skip done");
  endtask : t_skip

  // Main sequence: preload, reset for two cycles, then the scenarios.
  initial begin
    RST = 1'b1;
    INSTR_VALID = 1'b0;
    INSTR = '0;
    acc_m = 8'h00;
    flg_m = '0;
    for (int i = 0; i < 128; i++) begin
      fr[i] = 8'(i * 37 + 5);
      file_u.mem[i] = fr[i];
    end
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    #1;
    chk(ACC, 8'h00);
    chk({5'h00, FLAGS}, 8'h00);
    t_arith();
    t_bits();
    t_skip();
    conclude();
  end

  // Watchdog, well beyond the roughly seventy cycles the scenarios need.
  initial begin
    repeat (3000) @(posedge CLK);
    n_fail++;
    conclude();
  end
endmodule : tb_top
